// ==== design/gain_decode.sv ====
// Audio taper decode of the gain word into per-channel gain in 0.1 dB
`include "headphone_gain_regs.svh"
module gain_decode (
   gain_if.dec gif
);
   import headphone_gain_pkg::*;

   function automatic tenth_db_t taper(input logic [5:0] step);
      // Plain integers in the table; one sized cast narrows the result
      int t [64];
      t = '{-595, -535, -500, -475, -455, -439, -414, -395,
            -365, -353, -333, -317, -304, -286, -271, -263,
            -247, -237, -225, -217, -205, -196, -188, -178,
            -170, -162, -152, -145, -137, -130, -123, -116,
            -109, -103, -97, -90, -85, -78, -72, -67,
            -61, -56, -51, -45, -41, -35, -31, -26,
            -21, -17, -12, -8, -3, 1, 5, 9,
            14, 17, 21, 25, 29, 33, 36, 40};
      return tenth_db_t'(t[step]);
   endfunction

   wire tenth_db_t step_gain = taper(gif.word[5:0]);
   wire both_muted = &gif.word[`MUTE_LEFT_BIT:`MUTE_RIGHT_BIT];

   genvar c;
   generate
      // Channel 0 is left (bit 7), channel 1 is right (bit 6)
      for (c = 0; c < 2; c++) begin : g_ch
         wire muted = gif.word[`MUTE_LEFT_BIT - c] | both_muted;
         assign gif.gain_ch[c] = muted ? `MUTED_TENTH_DB : step_gain;
      end
   endgenerate
endmodule

// ==== design/headphone_gain_i2c_control.sv ====
// I2C target with the gain and mute control word of a headphone amplifier
//
// Overview of operation
// - The six-bit step code selects one of 64 audio taper gains.
// - Both mute bits set gives -100 dB regardless of the step code.
// - Unmuted gain rises with code, -59.5 dB at 0 to 4.0 dB at 63.
// - Address and data travel as 8-bit bytes, most significant bit first.
// - The receiver of each byte acknowledges in the following clock period.
// - SDA falling with SCL high is start; rising with SCL high is stop.
// - SDA data changes only while SCL is low.
// - The target holds SDA low through the acknowledge clock high phase.
// - The target only pulls SDA low or releases it.
// - Any number of data bytes may follow between start and stop.
// - Bit 7 mutes left, bit 6 mutes right, independently.
// - Reset leaves both mutes on and the step code at -59.5 dB.
// - First write byte picks the register, later bytes go to the next ones.
`include "headphone_gain_regs.svh"
module headphone_gain_i2c_control #(
   // Arbitrary value; set to the address strapped for the part
   parameter logic [6:0] TARGET_ADDR = 7'h2A
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output headphone_gain_pkg::byte_t gain_word_o,
   output logic mute_left_o,
   output logic mute_right_o,
   output headphone_gain_pkg::tenth_db_t gain_left_o,
   output headphone_gain_pkg::tenth_db_t gain_right_o
);
   import headphone_gain_pkg::*;

   logic [1:0] pins_sync;
   logic scl_prev_reg;
   logic sda_prev_reg;
   link_state_t state_reg;
   byte_phase_t phase_reg;
   logic rw_reg;
   logic [3:0] bit_cnt_reg;
   byte_t shift_reg;
   byte_t ptr_reg;
   byte_t gain_reg;
   logic sda_oe_reg;
   logic sda_out_reg;
   tenth_db_t gain_left_reg;
   tenth_db_t gain_right_reg;

   gain_if gif ();

   pin_sync u_sync (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .pin_i({scl_i, sda_i}),
      .sync_o(pins_sync)
   );

   gain_decode u_decode (
      .gif(gif.dec)
   );

   assign gif.word = gain_reg;

   wire scl_s = pins_sync[1];
   wire sda_s = pins_sync[0];
   wire scl_rise = scl_s & ~scl_prev_reg;
   wire scl_fall = ~scl_s & scl_prev_reg;
   wire scl_held = scl_s & scl_prev_reg;
   wire start_seen = scl_held & sda_prev_reg & ~sda_s;
   wire stop_seen = scl_held & ~sda_prev_reg & sda_s;
   wire byte_done = bit_cnt_reg == `BYTE_BITS;
   wire addr_match = shift_reg[7:1] == TARGET_ADDR;
   wire gain_sel = ptr_reg == `GAIN_REG_INDEX;
   wire byte_t read_byte = gain_sel ? gain_reg : 8'h00;
   wire byte_t ptr_next = ptr_reg + 8'h01;
   wire byte_t shift_next = {shift_reg[6:0], sda_s};
   wire byte_t gain_next = shift_reg;
   wire gain_write = state_reg == RX && scl_fall && byte_done &&
                     phase_reg == PH_DATA && gain_sel;
   wire rx_taken = state_reg == RX && scl_fall && byte_done;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_prev_reg <= scl_s;
         sda_prev_reg <= sda_s;
      end
   end

   // Gain word; only a complete data byte may change it
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gain_reg <= `GAIN_RESET;
      end else if (gain_write) begin
         gain_reg <= gain_next;
      end
   end

   // Output copies, so every top output comes from a flip-flop
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sda_out_reg <= 1'b0;
         gain_left_reg <= `MUTED_TENTH_DB;
         gain_right_reg <= `MUTED_TENTH_DB;
      end else begin
         sda_out_reg <= 1'b0;
         gain_left_reg <= gif.gain_ch[0];
         gain_right_reg <= gif.gain_ch[1];
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= IDLE;
         phase_reg <= PH_ADDR;
         rw_reg <= 1'b0;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         sda_oe_reg <= 1'b0;
      end else if (start_seen) begin
         // A repeated start keeps the register pointer for a read
         state_reg <= RX;
         phase_reg <= PH_ADDR;
         bit_cnt_reg <= 4'h0;
         sda_oe_reg <= 1'b0;
      end else if (stop_seen) begin
         state_reg <= IDLE;
         sda_oe_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            IDLE: begin
               sda_oe_reg <= 1'b0;
            end
            RX: begin
               if (scl_rise && !byte_done) begin
                  shift_reg <= shift_next;
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (rx_taken) begin
                  bit_cnt_reg <= 4'h0;
                  unique case (phase_reg)
                     PH_ADDR: begin
                        if (addr_match) begin
                           rw_reg <= shift_reg[0];
                           phase_reg <= shift_reg[0] ? PH_DATA : PH_PTR;
                           state_reg <= ACK;
                           sda_oe_reg <= 1'b1;
                        end else begin
                           state_reg <= IDLE;
                        end
                     end
                     PH_PTR: begin
                        ptr_reg <= shift_reg;
                        phase_reg <= PH_DATA;
                        state_reg <= ACK;
                        sda_oe_reg <= 1'b1;
                     end
                     default: begin
                        ptr_reg <= ptr_next;
                        state_reg <= ACK;
                        sda_oe_reg <= 1'b1;
                     end
                  endcase
               end
            end
            ACK: begin
               // Released on the falling edge, so SCL high sees it held
               if (scl_fall) begin
                  if (rw_reg == `RW_READ) begin
                     state_reg <= TX;
                     shift_reg <= read_byte;
                     sda_oe_reg <= ~read_byte[7];
                     bit_cnt_reg <= 4'h1;
                  end else begin
                     state_reg <= RX;
                     sda_oe_reg <= 1'b0;
                  end
               end
            end
            TX: begin
               if (scl_fall) begin
                  if (byte_done) begin
                     state_reg <= TX_ACK;
                     sda_oe_reg <= 1'b0;
                     ptr_reg <= ptr_next;
                  end else begin
                     shift_reg <= {shift_reg[6:0], 1'b0};
                     sda_oe_reg <= ~shift_reg[6];
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            TX_ACK: begin
               // Controller not-acknowledge ends the read
               if (scl_rise && sda_s) begin
                  state_reg <= IDLE;
               end else if (scl_fall) begin
                  state_reg <= TX;
                  shift_reg <= read_byte;
                  sda_oe_reg <= ~read_byte[7];
                  bit_cnt_reg <= 4'h1;
               end
            end
         endcase
      end
   end

   assign sda_o = sda_out_reg;
   assign sda_oe_o = sda_oe_reg;
   assign gain_word_o = gain_reg;
   assign mute_left_o = gain_reg[`MUTE_LEFT_BIT];
   assign mute_right_o = gain_reg[`MUTE_RIGHT_BIT];
   assign gain_left_o = gain_left_reg;
   assign gain_right_o = gain_right_reg;

   a_ack_held_high: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      (state_reg == ACK && scl_s) |-> sda_oe_reg)
      else $error("ack released during SCL high");

   a_sda_released: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      sda_oe_reg |-> (state_reg == ACK || state_reg == TX))
      else $error("SDA driven outside ack or read data");

   a_sda_stable_high: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      (scl_held && !start_seen && !stop_seen) |=> $stable(sda_oe_reg))
      else $error("SDA drive changed while SCL high");

   a_start_restarts: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      start_seen |=> (state_reg == RX && bit_cnt_reg == 4'h0 &&
                      phase_reg == PH_ADDR))
      else $error("start did not restart address reception");

   a_stop_idles: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      stop_seen |=> (state_reg == IDLE && !sda_oe_reg))
      else $error("stop did not idle the target");

   a_ack_follows: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      (rx_taken && phase_reg != PH_ADDR) |=> (state_reg == ACK && sda_oe_o)
      ##1 (state_reg == ACK))
      else $error("received byte not acknowledged");

   a_gain_only_bytes: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      $changed(gain_reg) |-> $past(gain_write))
      else $error("gain word changed without a full data byte");

   a_both_mute: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      (&gain_reg[7:6]) |=> (gain_left_o == `MUTED_TENTH_DB &&
                            gain_right_o == `MUTED_TENTH_DB))
      else $error("both mutes did not give muted gain");

   a_one_mute_only: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      (gain_reg[7:6] == 2'b10 && $stable(gain_reg)) |=>
      (gain_left_o == `MUTED_TENTH_DB &&
       gain_right_o != `MUTED_TENTH_DB))
      else $error("left mute not independent");

   a_taper_top: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      (gain_reg == 8'h3F) |=> (gain_left_o == `STEP_MAX_TENTH_DB))
      else $error("taper top step wrong");

   a_taper_bottom: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      (gain_reg == 8'h00) |=> (gain_right_o == `STEP_MIN_TENTH_DB))
      else $error("taper bottom step wrong");

   a_right_mute_only: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      (gain_reg[7:6] == 2'b01 && $stable(gain_reg)) |=>
      (gain_right_o == `MUTED_TENTH_DB &&
       gain_left_o != `MUTED_TENTH_DB))
      else $error("right mute not independent");

   a_addr_acked: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      (rx_taken && phase_reg == PH_ADDR && addr_match) |=>
      (state_reg == ACK && sda_oe_o))
      else $error("own address not acknowledged");

   a_foreign_ignored: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      (rx_taken && phase_reg == PH_ADDR && !addr_match) |=>
      (state_reg == IDLE && !sda_oe_o))
      else $error("foreign address not ignored");

   a_sda_only_low: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      !sda_o)
      else $error("SDA data driven high");

   a_ptr_advances: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      (rx_taken && phase_reg == PH_DATA) |=>
      (ptr_reg == $past(ptr_reg) + 8'h01))
      else $error("register pointer did not advance");

   a_bit_count_max: assert property (@(posedge clock_i)
      disable iff (!rst_b_i)
      bit_cnt_reg <= `BYTE_BITS)
      else $error("bit counter ran past a byte");
endmodule

// ==== design/pin_sync.sv ====
// Two-stage synchroniser for the bus pins
module pin_sync (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [1:0] pin_i,
   output logic [1:0] sync_o
);
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_bit
         logic meta_reg;
         logic stable_reg;
         // Idle bus level is high, so reset to high to avoid a false start
         always_ff @(posedge clock_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               meta_reg <= 1'b1;
               stable_reg <= 1'b1;
            end else begin
               meta_reg <= pin_i[g];
               stable_reg <= meta_reg;
            end
         end
         assign sync_o[g] = stable_reg;
      end
   endgenerate
endmodule

// ==== inc/gain_if.sv ====
// Carries the gain word to the decoder and the per-channel gains back
interface gain_if;
   import headphone_gain_pkg::*;
   byte_t word;
   tenth_db_t gain_ch [2];
   modport ctl (output word, input gain_ch);
   modport dec (input word, output gain_ch);
endinterface

// ==== inc/headphone_gain_pkg.sv ====
// Types shared by the headphone gain control modules
package headphone_gain_pkg;
   typedef enum logic [2:0] {
      IDLE, RX, ACK, TX, TX_ACK
   } link_state_t;
   typedef enum logic [1:0] {
      PH_ADDR, PH_PTR, PH_DATA
   } byte_phase_t;
   typedef logic signed [10:0] tenth_db_t;
   typedef logic [7:0] byte_t;
endpackage

// ==== inc/headphone_gain_regs.svh ====
// Register offsets, field positions, reset values and gain figures
`ifndef HEADPHONE_GAIN_REGS_SVH
`define HEADPHONE_GAIN_REGS_SVH

`define GAIN_REG_INDEX 8'h02
`define MUTE_LEFT_BIT 7
`define MUTE_RIGHT_BIT 6
`define GAIN_RESET 8'hC0
`define MUTED_TENTH_DB 11'sh418
`define STEP_MIN_TENTH_DB 11'sh5AD
`define STEP_MAX_TENTH_DB 11'sh028
`define BYTE_BITS 4'h8
`define RW_READ 1'b1

`endif

// ==== verif/bus_host_model.sv ====
// Behavioural bus controller that drives the gain block's serial pins
module bus_host_model (
   input wire logic clock_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   // Data moves mid low phase and is read mid high phase
   task automatic bit_io(input logic b, output logic seen);
      tick(2);
      sda_low_o <= ~b;
      tick(2);
      scl_o <= 1'b1;
      tick(2);
      seen = sda_i;
      tick(2);
      scl_o <= 1'b0;
   endtask
   // Also serves as a repeated start when entered with SCL low
   task automatic start();
      tick(2);
      sda_low_o <= 1'b0;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      sda_low_o <= 1'b1;
      tick(4);
      scl_o <= 1'b0;
   endtask
   task automatic stop();
      tick(2);
      sda_low_o <= 1'b1;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      sda_low_o <= 1'b0;
      tick(4);
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic recv(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         b[i] = s;
      end
      bit_io(~ack, s);
   endtask
endmodule

// ==== verif/headphone_gain_i2c_control_bench.sv ====
// Self-checking bench for the headphone gain serial control block
module headphone_gain_i2c_control_bench import headphone_gain_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // Arbitrary value, matches the design default
   localparam logic [6:0] ADDR = 7'h2A;
   localparam int MUTED = -1000;
   localparam int LIMIT = 40000;
   int taper [64] = '{-595, -535, -500, -475, -455, -439, -414,
      -395, -365, -353, -333, -317, -304, -286, -271, -263, -247, -237,
      -225, -217, -205, -196, -188, -178, -170, -162, -152, -145, -137,
      -130, -123, -116, -109, -103, -97, -90, -85, -78, -72, -67, -61,
      -56, -51, -45, -41, -35, -31, -26, -21, -17, -12, -8, -3, 1, 5, 9,
      14, 17, 21, 25, 29, 33, 36, 40};
   logic clock_i, rst_b_i, scl, sda_low, sda_oe, sda_out, mute_l, mute_r;
   byte_t word;
   tenth_db_t gain_l, gain_r;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   wire logic sda_line = ~(sda_low | (sda_oe & ~sda_out));

   headphone_gain_i2c_control #(.TARGET_ADDR(ADDR)) dut_u (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .scl_i(scl),
      .sda_i(sda_line), .sda_o(sda_out), .sda_oe_o(sda_oe),
      .gain_word_o(word), .mute_left_o(mute_l), .mute_right_o(mute_r),
      .gain_left_o(gain_l), .gain_right_o(gain_r));
   bus_host_model host_u (.clock_i(clock_i), .sda_i(sda_line),
      .scl_o(scl), .sda_low_o(sda_low));

   task automatic summarize();
      if (errors == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check_bit(input string what, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic check_byte(input string what, input byte_t e, byte_t g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic check_gain(input string what, input int e,
      input tenth_db_t g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %0d seen %0d", what, e, g);
      end
   endtask
   task automatic send_ack(input byte_t b, input logic e);
      logic a;
      host_u.send(b, a);
      check_bit("ack", e, a);
   endtask
   task automatic write_reg(input byte_t ptr, input byte_t d);
      host_u.start();
      send_ack({ADDR, 1'b0}, 1'b1);
      send_ack(ptr, 1'b1);
      send_ack(d, 1'b1);
      host_u.stop();
   endtask
   task automatic check_out(input byte_t w, input int l, input int r);
      check_byte("gain_word", w, word);
      check_bit("mute_left", w[7], mute_l);
      check_bit("mute_right", w[6], mute_r);
      check_gain("gain_left", l, gain_l);
      check_gain("gain_right", r, gain_r);
   endtask
   task automatic partial_byte();
      logic s;
      for (int i = 0; i < 4; i++) begin
         host_u.bit_io(1'b1, s);
      end
   endtask

   task automatic test_reset();
      check_out(8'hC0, MUTED, MUTED);
      check_bit("sda_drive", 1'b0, sda_oe);
      check_bit("sda_out", 1'b0, sda_out);
   endtask
   // A reset in mid-run must bring back the start-up word
   task automatic test_reset_again();
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      test_reset();
   endtask
   task automatic test_taper();
      for (int c = 0; c < 64; c++) begin
         write_reg(8'h02, 8'(c));
         check_out(8'(c), taper[c], taper[c]);
      end
   endtask
   task automatic test_mutes();
      write_reg(8'h02, 8'hBF);
      check_out(8'hBF, MUTED, taper[63]);
      write_reg(8'h02, 8'h7F);
      check_out(8'h7F, taper[63], MUTED);
      write_reg(8'h02, 8'hE5);
      check_out(8'hE5, MUTED, MUTED);
   endtask
   task automatic test_burst();
      host_u.start();
      send_ack({ADDR, 1'b0}, 1'b1);
      send_ack(8'h01, 1'b1);
      send_ack(8'h00, 1'b1);
      send_ack(8'h15, 1'b1);
      send_ack(8'h00, 1'b1);
      send_ack(8'h00, 1'b1);
      host_u.stop();
      check_out(8'h15, taper[21], taper[21]);
   endtask
   task automatic test_read();
      byte_t d;
      host_u.start();
      send_ack({ADDR, 1'b0}, 1'b1);
      send_ack(8'h02, 1'b1);
      host_u.start();
      send_ack({ADDR, 1'b1}, 1'b1);
      host_u.recv(1'b1, d);
      check_byte("read_reg2", 8'h15, d);
      host_u.recv(1'b0, d);
      check_byte("read_reg3", 8'h00, d);
      host_u.stop();
      check_bit("sda_drive", 1'b0, sda_oe);
   endtask
   task automatic test_foreign();
      host_u.start();
      send_ack({ADDR ^ 7'h01, 1'b0}, 1'b0);
      send_ack(8'h02, 1'b0);
      send_ack(8'h3F, 1'b0);
      host_u.stop();
      check_out(8'h15, taper[21], taper[21]);
   endtask
   // A start then a stop cut a data byte short; neither may land
   task automatic test_abort();
      host_u.start();
      send_ack({ADDR, 1'b0}, 1'b1);
      send_ack(8'h02, 1'b1);
      partial_byte();
      host_u.start();
      send_ack({ADDR, 1'b0}, 1'b1);
      send_ack(8'h02, 1'b1);
      partial_byte();
      host_u.stop();
      check_out(8'h15, taper[21], taper[21]);
      write_reg(8'h02, 8'h20);
      check_out(8'h20, taper[32], taper[32]);
   endtask

   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errors++;
         summarize();
      end
   end
   initial begin
      rst_b_i = 1'b0;
      repeat (20) @(posedge clock_i);
      rst_b_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      test_reset();
      test_taper();
      test_mutes();
      test_burst();
      test_read();
      test_foreign();
      test_abort();
      test_reset_again();
      summarize();
   end
endmodule
